/* File: src/machine_trap_unit.sv */
// Purpose: Machine-mode trap entry, return and trap CSRs of the core
// Assumes: Pipeline reports one exception per boundary; pins are async
// Notes:   Vector table read is requested from fetch, not done here
//
// What this block does
// - Three interrupt pins: timer, software, external; timer and software are local
// - Internal interrupts on bus error and performance counter overflow
// - Pending and enable bit per interrupt; global enable blocks all
// - Enables at bits 3, 7, 11, 17, 18, read/write, reset zero
// - Priority: perf overflow, bus error, external, software, timer
// - Return address is the faulting or interrupted instruction
// - Entry saves privilege to 12:11, enable 3 to 7, clears enable
// - Entry updates cause and switches to machine mode
// - Misaligned and access-fault exceptions also write trap value
// - Vectored mode off: jump to the vector base
// - Vectored mode on: base starts a table of 4-byte entries
// - Exceptions and local interrupts use entry zero with standard cause
// - External source i uses table entry i
// - Return loads PC from saved address, privilege from prior field
// - Return restores enable, sets prior enable 1, prior privilege user
// - Return uses whatever software wrote into the saved fields
// - Prior privilege 0 user, 3 machine; resets to 3, enables to 0
// - Illegal instruction on bad opcode, privilege or CSR misuse
// - Fetch and load bus errors raise access faults
// - Misaligned jumps, breakpoints, calls, stack faults raise exceptions
// - Cause bit 31 marks interrupts except vectored external (source ID); codes 3, 7, 11, 17, 18
// - Exception codes 0 to 8, 11, 32 and 33
// - Vector base low two bits read zero
// - Pending 3, 7, 11 read-only; 17, 18 read/write
`timescale 1ns/1ps
`default_nettype none
module machine_trap_unit
    import trap_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        timer_interrupt,
    input  wire logic        software_interrupt,
    input  wire logic        external_interrupt,
    input  wire logic [9:0]  ext_source_id,
    input  wire logic        bus_error_event,
    input  wire logic        perf_overflow_event,
    input  wire logic        boundary,
    input  wire logic [31:0] boundary_pc,
    input  wire exc_req_t    exc,
    input  wire logic        mret,
    input  wire csr_req_t    csr,
    output logic [31:0]      csr_rdata,
    output logic             csr_illegal,
    output redirect_t        redirect,
    output logic [1:0]       priv_level
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic [9:0] src_id_r;
    logic [9:0] src_id_nxt;
    sync2 #(.W(3)) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .d       ({external_interrupt, software_interrupt, timer_interrupt}),
        .q       (pins_s)
    );
    // Source ID rides with the request; two-cycle delay is matched
    logic [9:0] src_meta_r;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            src_meta_r <= '0;
            src_id_r   <= '0;
        end else if (ce) begin
            src_meta_r <= ext_source_id;
            src_id_r   <= src_id_nxt;
        end
    end
    assign src_id_nxt = src_meta_r;

    // ------------------------------------------------------------
    // Architectural state
    // ------------------------------------------------------------
    logic        gie_r, gie_nxt;
    logic        pie_r, pie_nxt;
    logic [1:0]  pp_r, pp_nxt;
    logic [1:0]  priv_r, priv_nxt;
    logic [31:0] ie_r, ie_nxt;
    logic        ip_bus_r, ip_bus_nxt;
    logic        ip_prf_r, ip_prf_nxt;
    logic [31:0] tvec_r, tvec_nxt;
    logic [31:0] epc_r, epc_nxt;
    logic [31:0] cause_r, cause_nxt;
    logic [31:0] tval_r, tval_nxt;
    logic        vecmode_r, vecmode_nxt;
    redirect_t   redir_r, redir_nxt;

    logic [31:0] status_view;
    logic [31:0] ip_view;
    logic        int_take;
    logic [4:0]  int_code;
    trap_kind_t  kind;

    // Status word as seen by software
    always_comb begin
        status_view = '0;
        status_view[GIE_BIT] = gie_r;
        status_view[PIE_BIT] = pie_r;
        status_view[PP_HI:PP_LO] = pp_r;
    end

    // Pin pendings read-only, internal ones writable
    always_comb begin
        ip_view = '0;
        ip_view[SWI_BIT] = pins_s[1];
        ip_view[TMI_BIT] = pins_s[0];
        ip_view[EXI_BIT] = pins_s[2];
        ip_view[BUS_BIT] = ip_bus_r;
        ip_view[PRF_BIT] = ip_prf_r;
    end

    // Arbitration of pending and enabled interrupts
    irq_pick u_pick (
        .pending (ip_view),
        .enable  (ie_r),
        .gie     (gie_r),
        .take    (int_take),
        .code    (int_code)
    );

    // Traps only at a boundary; exception beats interrupt there
    always_comb begin
        kind = TK_NONE;
        if (boundary && exc.valid) begin
            kind = TK_EXC;
        end else if (boundary && int_take) begin
            kind = TK_INT;
        end
    end

    // Codes that carry a faulting address into the trap value
    function automatic logic addr_exc(input logic [5:0] c);
        addr_exc = (c == EXC_IMISALIGN) || (c == EXC_IFAULT) ||
                   (c == EXC_LMISALIGN) || (c == EXC_LFAULT) ||
                   (c == EXC_SMISALIGN) || (c == EXC_SFAULT);
    endfunction

    // Known CSR address check
    function automatic logic csr_known(input logic [11:0] a);
        csr_known = (a == CSR_STATUS) || (a == CSR_IE) || (a == CSR_TVEC) ||
                    (a == CSR_EPC) || (a == CSR_CAUSE) || (a == CSR_TVAL) ||
                    (a == CSR_IP) || (a == CSR_MISC);
    endfunction

    // Unknown CSR or access from user mode is illegal
    assign csr_illegal = (csr.rd || csr.wr) &&
                         (!csr_known(csr.addr) || (priv_r != PRIV_MACHINE));

    // ------------------------------------------------------------
    // Next-state logic: CSR writes, trap entry, return
    // ------------------------------------------------------------
    always_comb begin
        gie_nxt     = gie_r;
        pie_nxt     = pie_r;
        pp_nxt      = pp_r;
        priv_nxt    = priv_r;
        ie_nxt      = ie_r;
        ip_bus_nxt  = ip_bus_r;
        ip_prf_nxt  = ip_prf_r;
        tvec_nxt    = tvec_r;
        epc_nxt     = epc_r;
        cause_nxt   = cause_r;
        tval_nxt    = tval_r;
        vecmode_nxt = vecmode_r;
        redir_nxt   = '0;
        // Software writes first so that hardware events below win
        if (csr.wr && !csr_illegal) begin
            if (csr.addr == CSR_STATUS) begin
                gie_nxt = csr.wdata[GIE_BIT];
                pie_nxt = csr.wdata[PIE_BIT];
                // Reserved privilege codes are not stored
                if (csr.wdata[PP_HI:PP_LO] == PRIV_USER ||
                    csr.wdata[PP_HI:PP_LO] == PRIV_MACHINE) begin
                    pp_nxt = csr.wdata[PP_HI:PP_LO];
                end
            end else if (csr.addr == CSR_IE) begin
                // Only the five enable bits are stored
                ie_nxt = csr.wdata & IE_MASK;
            end else if (csr.addr == CSR_TVEC) begin
                tvec_nxt = csr.wdata & TVEC_MASK;
            end else if (csr.addr == CSR_EPC) begin
                epc_nxt = csr.wdata & EPC_MASK;
            end else if (csr.addr == CSR_CAUSE) begin
                cause_nxt = csr.wdata;
            end else if (csr.addr == CSR_TVAL) begin
                tval_nxt = csr.wdata;
            end else if (csr.addr == CSR_IP) begin
                ip_bus_nxt = csr.wdata[BUS_BIT];
                ip_prf_nxt = csr.wdata[PRF_BIT];
            end else if (csr.addr == CSR_MISC) begin
                vecmode_nxt = csr.wdata[0];
            end
        end
        // Internal events set pending; set wins over a clear
        if (bus_error_event) begin
            ip_bus_nxt = 1'b1;
        end
        if (perf_overflow_event) begin
            ip_prf_nxt = 1'b1;
        end
        if (kind != TK_NONE) begin
            // Return address of the boundary instruction
            epc_nxt = (kind == TK_EXC) ? (exc.pc & EPC_MASK) : (boundary_pc & EPC_MASK);
            // Save privilege and enable, then mask
            pp_nxt  = priv_r;
            pie_nxt = gie_r;
            gie_nxt = 1'b0;
            priv_nxt = PRIV_MACHINE;
            redir_nxt.valid  = 1'b1;
            redir_nxt.target = tvec_r;
            if (kind == TK_EXC) begin
                cause_nxt = {26'h0, exc.code};
                redir_nxt.vec_fetch = vecmode_r; // Entry zero when vectored
                // Faulting address for misaligned and fault codes
                if (addr_exc(exc.code)) begin
                    tval_nxt = exc.tval;
                end
            end else if (vecmode_r && int_code == 5'(EXI_BIT)) begin
                // Entry i of the table, cause holds the source ID
                cause_nxt = {22'h0, src_id_r};
                redir_nxt.vec_fetch = 1'b1;
                redir_nxt.target = tvec_r + ({22'h0, src_id_r} * VEC_ENTRY_BYTES);
            end else begin
                cause_nxt = {1'b1, 26'h0, int_code};
                redir_nxt.vec_fetch = vecmode_r;
            end
            // Non-vectored target stays the base itself
        end else if (boundary && mret && priv_r == PRIV_MACHINE) begin
            // Live saved values drive the return
            redir_nxt.valid  = 1'b1;
            redir_nxt.target = epc_r;
            priv_nxt = pp_r;
            // Restore and reset the saved context
            gie_nxt = pie_r;
            pie_nxt = 1'b1;
            pp_nxt  = PRIV_USER;
        end
    end

    // Registers, frozen while ce is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gie_r     <= 1'b0;
            pie_r     <= 1'b0;
            pp_r      <= PRIV_MACHINE;
            priv_r    <= PRIV_MACHINE;
            ie_r      <= '0;
            ip_bus_r  <= 1'b0;
            ip_prf_r  <= 1'b0;
            tvec_r    <= '0;
            epc_r     <= '0;
            cause_r   <= '0;
            tval_r    <= '0;
            vecmode_r <= 1'b0;
            redir_r   <= '0;
        end else if (ce) begin
            gie_r     <= gie_nxt;
            pie_r     <= pie_nxt;
            pp_r      <= pp_nxt;
            priv_r    <= priv_nxt;
            ie_r      <= ie_nxt;
            ip_bus_r  <= ip_bus_nxt;
            ip_prf_r  <= ip_prf_nxt;
            tvec_r    <= tvec_nxt;
            epc_r     <= epc_nxt;
            cause_r   <= cause_nxt;
            tval_r    <= tval_nxt;
            vecmode_r <= vecmode_nxt;
            redir_r   <= redir_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        csr_rdata = '0;
        if (!csr.rd || csr_illegal) begin
            csr_rdata = '0;
        end else if (csr.addr == CSR_STATUS) begin
            csr_rdata = status_view;
        end else if (csr.addr == CSR_IE) begin
            csr_rdata = ie_r;
        end else if (csr.addr == CSR_TVEC) begin
            csr_rdata = tvec_r;
        end else if (csr.addr == CSR_EPC) begin
            csr_rdata = epc_r;
        end else if (csr.addr == CSR_CAUSE) begin
            csr_rdata = cause_r;
        end else if (csr.addr == CSR_TVAL) begin
            csr_rdata = tval_r;
        end else if (csr.addr == CSR_IP) begin
            csr_rdata = ip_view;
        end else if (csr.addr == CSR_MISC) begin
            csr_rdata = {31'h0, vecmode_r};
        end
    end

    assign redirect   = redir_r;
    assign priv_level = priv_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_entry_masks: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && kind != TK_NONE) |=> (!gie_r && pie_r == $past(gie_r) && priv_r == PRIV_MACHINE))
        else $error("trap entry did not save and mask enable");
    chk_int_cause_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && kind == TK_INT && !vecmode_r) |=> (cause_r[CAUSE_INT_BIT] && redir_r.valid))
        else $error("interrupt cause lacks flag");
    chk_no_int_masked: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!gie_r) |-> (kind != TK_INT))
        else $error("interrupt taken with global enable clear");
    chk_prf_priority: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && kind == TK_INT && ip_prf_r && ie_r[PRF_BIT] && !vecmode_r)
        |=> (cause_r[4:0] == 5'(PRF_BIT)))
        else $error("perf overflow not highest priority");
    chk_ret_restore: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && kind == TK_NONE && boundary && mret && priv_r == PRIV_MACHINE)
        |=> (gie_r == $past(pie_r) && pie_r && pp_r == PRIV_USER && redir_r.target == $past(epc_r)))
        else $error("return did not restore context");
    chk_tvec_align: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tvec_r[1:0] == 2'h0)
        else $error("vector base not word aligned");
    chk_bus_set_wins: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && bus_error_event) |=> ip_bus_r)
        else $error("bus error pending lost");
    chk_direct_target: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && kind != TK_NONE && !vecmode_r) |=> (redir_r.target == $past(tvec_r) && !redir_r.vec_fetch))
        else $error("direct mode target wrong");
endmodule // machine_trap_unit
`default_nettype wire

/* File: src/trap_pkg.sv */
// Purpose: Shared constants and types for the machine trap unit
// Assumes: 32-bit core, control registers reached by 12-bit CSR address
// Notes:   All field positions, codes and masks live here
package trap_pkg;
    // CSR addresses
    localparam logic [11:0] CSR_STATUS  = 12'h300;
    localparam logic [11:0] CSR_IE      = 12'h304;
    localparam logic [11:0] CSR_TVEC    = 12'h305;
    localparam logic [11:0] CSR_EPC     = 12'h341;
    localparam logic [11:0] CSR_CAUSE   = 12'h342;
    localparam logic [11:0] CSR_TVAL    = 12'h343;
    localparam logic [11:0] CSR_IP      = 12'h344;
    localparam logic [11:0] CSR_MISC    = 12'h7d0;
    // Status fields
    localparam int GIE_BIT   = 3;
    localparam int PIE_BIT   = 7;
    localparam int PP_LO     = 11;
    localparam int PP_HI     = 12;
    localparam logic [1:0] PRIV_USER    = 2'h0;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;
    // Interrupt bit positions, shared by enable, pending and cause code
    localparam int SWI_BIT   = 3;
    localparam int TMI_BIT   = 7;
    localparam int EXI_BIT   = 11;
    localparam int BUS_BIT   = 17;
    localparam int PRF_BIT   = 18;
    localparam logic [31:0] IE_MASK = 32'h0006_0888;
    localparam logic [31:0] IP_RW_MASK = 32'h0006_0000;
    localparam int CAUSE_INT_BIT = 31;
    localparam logic [31:0] TVEC_MASK = 32'hffff_fffc;
    localparam logic [31:0] EPC_MASK  = 32'hffff_fffe;
    localparam logic [31:0] VEC_ENTRY_BYTES = 32'h0000_0004;
    // Exception codes
    localparam logic [5:0] EXC_IMISALIGN = 6'h00;
    localparam logic [5:0] EXC_IFAULT    = 6'h01;
    localparam logic [5:0] EXC_ILLEGAL   = 6'h02;
    localparam logic [5:0] EXC_BREAK     = 6'h03;
    localparam logic [5:0] EXC_LMISALIGN = 6'h04;
    localparam logic [5:0] EXC_LFAULT    = 6'h05;
    localparam logic [5:0] EXC_SMISALIGN = 6'h06;
    localparam logic [5:0] EXC_SFAULT    = 6'h07;
    localparam logic [5:0] EXC_ECALL_U   = 6'h08;
    localparam logic [5:0] EXC_ECALL_M   = 6'h0b;
    localparam logic [5:0] EXC_STK_OVER  = 6'h20;
    localparam logic [5:0] EXC_STK_UNDER = 6'h21;
    localparam int EXC_COUNT = 12;

    // Exception report from the pipeline for the instruction at the boundary
    typedef struct packed {
        logic        valid;
        logic [5:0]  code;
        logic [31:0] pc;
        logic [31:0] tval;
    } exc_req_t;

    // CSR access from the pipeline
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csr_req_t;

    // Redirect to the fetch unit
    typedef struct packed {
        logic        valid;
        logic        vec_fetch;
        logic [31:0] target;
    } redirect_t;

    // Trap kind chosen this cycle
    typedef enum logic [2:0] {
        TK_NONE = 3'b001,
        TK_EXC  = 3'b010,
        TK_INT  = 3'b100
    } trap_kind_t;
endpackage

/* File: src/irq_pick.sv */
// Purpose: Fixed-priority selection among enabled, pending interrupts
// Assumes: Inputs from the same clock domain
// Notes:   Pure combinational
`timescale 1ns/1ps
`default_nettype none
module irq_pick
    import trap_pkg::*;
(
    input  wire logic [31:0] pending,
    input  wire logic [31:0] enable,
    input  wire logic        gie,
    output logic             take,
    output logic [4:0]       code
);
    logic [31:0] ready;
    assign ready = pending & enable & IE_MASK;

    // Highest first: perf overflow, bus error, external, software, timer
    always_comb begin
        take = gie;
        code = 5'(TMI_BIT);
        if (ready[PRF_BIT]) begin
            code = 5'(PRF_BIT);
        end else if (ready[BUS_BIT]) begin
            code = 5'(BUS_BIT);
        end else if (ready[EXI_BIT]) begin
            code = 5'(EXI_BIT);
        end else if (ready[SWI_BIT]) begin
            code = 5'(SWI_BIT);
        end else if (ready[TMI_BIT]) begin
            code = 5'(TMI_BIT);
        end else begin
            take = 1'b0;
        end
    end
endmodule // irq_pick
`default_nettype wire

/* File: src/sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous interrupt levels
// Assumes: Level inputs held long enough to be seen
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // Two stages, frozen while ce is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            q_r    <= '0;
        end else if (ce) begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end
    assign q = q_r;
endmodule // sync2
`default_nettype wire

/* File: tb/irq_sources.sv */
// Purpose: Far-side model of timer, software source and external controller
// Assumes: Bench sets the wanted levels; model drives pins on the clock
// Notes:   Source id is only valid while the external request stands
`timescale 1ns/1ps
`default_nettype none
module irq_sources (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [2:0] want,
    input  wire logic [9:0] want_id,
    output logic            timer_interrupt,
    output logic            software_interrupt,
    output logic            external_interrupt,
    output logic [9:0]      ext_source_id
);
    logic [9:0] last_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {external_interrupt, software_interrupt, timer_interrupt} <= 3'h0;
            ext_source_id <= 10'h000;
            last_r        <= 10'h000;
        end else begin
            {external_interrupt, software_interrupt, timer_interrupt} <= want;
            if (want[2]) begin
                ext_source_id <= want_id;
                last_r        <= want_id;
            end else begin
                ext_source_id <= ~last_r; // Released id must not look valid
            end
        end
    end
endmodule // irq_sources
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the machine trap unit
// Assumes: Inputs change at the falling edge
// Notes:   Redirect is checked at the falling edge after the taking edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import trap_pkg::*;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] e;
        logic        il;
    } row_t;
    logic        clk_sys, arst_n, ce, boundary, mret, bus_ev, prf_ev;
    logic        t_i, s_i, e_i, csr_illegal, il;
    logic [9:0]  src_id, want_id;
    logic [2:0]  want;
    logic [1:0]  priv_level;
    logic [31:0] boundary_pc, csr_rdata, rd;
    exc_req_t    exc;
    csr_req_t    csr;
    redirect_t   redirect;
    int          err_count, total_checks;
    logic [4:0]  codes [5] = '{5'h12, 5'h11, 5'h0b, 5'h03, 5'h07};
    row_t        rows [6] = '{
        '{CSR_IE, 32'hffff_ffff, IE_MASK, 1'b0},
        '{CSR_TVEC, 32'hffff_ffff, TVEC_MASK, 1'b0},
        '{CSR_IP, 32'hffff_ffff, IP_RW_MASK, 1'b0},
        '{CSR_IP, 32'h0, 32'h0, 1'b0},
        '{CSR_TVEC, 32'h0000_1000, 32'h0000_1000, 1'b0},
        '{12'h7ff, 32'hffff_ffff, 32'h0, 1'b1}};

    machine_trap_unit i_dut (.clk_sys, .arst_n, .ce, .timer_interrupt(t_i),
        .software_interrupt(s_i), .external_interrupt(e_i), .ext_source_id(src_id),
        .bus_error_event(bus_ev), .perf_overflow_event(prf_ev), .boundary,
        .boundary_pc, .exc, .mret, .csr, .csr_rdata, .csr_illegal, .redirect,
        .priv_level);
    irq_sources i_src (.clk_sys, .arst_n, .want, .want_id, .timer_interrupt(t_i),
        .software_interrupt(s_i), .external_interrupt(e_i), .ext_source_id(src_id));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // Read data is combinational, so it is sampled before the taking edge
    task automatic csr_op(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        csr = {~w, w, a, d};
        #1;
        rd = csr_rdata;
        il = csr_illegal;
        @(posedge clk_sys);
        @(negedge clk_sys);
        csr = '0;
    endtask
    task automatic trap(input logic e, input logic [5:0] c, input logic m,
                        input logic [33:0] x);
        @(negedge clk_sys);
        boundary = 1'b1;
        mret = m;
        exc = {e, c, 32'h200, 32'h55};
        @(posedge clk_sys);
        @(negedge clk_sys);
        boundary = 1'b0;
        mret = 1'b0;
        exc = '0;
        chk(redirect, x);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end

    initial begin
        {arst_n, boundary, mret, bus_ev, prf_ev, want, want_id} = '0;
        {ce, boundary_pc, exc, csr, err_count, total_checks} = {1'b1, 32'h400, 71'h0, 46'h0, 64'h0};
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        csr_op(1'b0, CSR_STATUS, 32'h0);
        chk(rd, 32'h1800);
        chk(priv_level, PRIV_MACHINE);
        csr_op(1'b0, CSR_IE, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            csr_op(1'b1, rows[i].a, rows[i].w);
            csr_op(1'b0, rows[i].a, 32'h0);
            chk({rd, il}, {rows[i].e, rows[i].il});
        end
        // Exception walk, then a return to a target rewritten by software
        csr_op(1'b1, CSR_STATUS, 32'h1808);
        trap(1'b1, EXC_LFAULT, 1'b0, {2'b10, 32'h1000});
        csr_op(1'b0, CSR_EPC, 32'h0);
        chk(rd, 32'h200);
        csr_op(1'b0, CSR_CAUSE, 32'h0);
        chk(rd, 32'h5);
        csr_op(1'b0, CSR_TVAL, 32'h0);
        chk(rd, 32'h55);
        csr_op(1'b0, CSR_STATUS, 32'h0);
        chk(rd, 32'h1880);
        csr_op(1'b1, CSR_EPC, 32'h344);
        csr_op(1'b1, CSR_STATUS, 32'h0080);
        trap(1'b0, 6'h0, 1'b1, {2'b10, 32'h344});
        chk(priv_level, PRIV_USER);
        csr_op(1'b0, CSR_STATUS, 32'h0);
        chk(il, 1'b1);
        trap(1'b1, EXC_ECALL_U, 1'b0, {2'b10, 32'h1000});
        chk(priv_level, PRIV_MACHINE);
        csr_op(1'b0, CSR_STATUS, 32'h0);
        chk(rd, 32'h0080);
        // All five sources at once, blocked first by the global enable
        csr_op(1'b1, CSR_STATUS, 32'h1800);
        want = 3'h7;
        @(negedge clk_sys);
        {bus_ev, prf_ev} = 2'h3;
        @(negedge clk_sys);
        {bus_ev, prf_ev} = 2'h0;
        repeat (4) @(negedge clk_sys);
        csr_op(1'b0, CSR_IP, 32'h0);
        chk(rd, 32'h0006_0888);
        trap(1'b0, 6'h0, 1'b0, 34'h0);
        for (int k = 0; k < 5; k++) begin
            csr_op(1'b1, CSR_STATUS, 32'h1808);
            trap(1'b0, 6'h0, 1'b0, {2'b10, 32'h1000});
            csr_op(1'b0, CSR_CAUSE, 32'h0);
            chk(rd, {1'b1, 26'h0, codes[k]});
            csr_op(1'b0, CSR_EPC, 32'h0);
            chk(rd, 32'h400);
            if (k < 2) begin
                csr_op(1'b1, CSR_IP, (k == 0) ? 32'h0002_0000 : 32'h0);
            end else begin
                want[4-k] = 1'b0;
            end
            repeat (4) @(negedge clk_sys);
        end
        // Vectored mode: external source picks its entry, exceptions entry zero
        csr_op(1'b1, CSR_MISC, 32'h1);
        want_id = 10'h005;
        want = 3'h4;
        repeat (4) @(negedge clk_sys);
        csr_op(1'b1, CSR_STATUS, 32'h1808);
        trap(1'b0, 6'h0, 1'b0, {2'b11, 32'h1014});
        csr_op(1'b0, CSR_CAUSE, 32'h0);
        chk(rd, 32'h5);
        want = 3'h0;
        trap(1'b1, EXC_BREAK, 1'b0, {2'b11, 32'h1000});
        // Reserved privilege code must leave the field alone
        csr_op(1'b1, CSR_STATUS, 32'h0800);
        csr_op(1'b0, CSR_STATUS, 32'h0);
        chk(rd, 32'h1800);
        // Clock enable low: a reported fault must not be taken
        ce = 1'b0;
        trap(1'b1, EXC_ILLEGAL, 1'b0, 34'h0);
        ce = 1'b1;
        csr_op(1'b0, CSR_CAUSE, 32'h0);
        chk(rd, 32'h3);
        // Reset in mid-run, then a return and a refused user-mode return
        arst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        chk(redirect, 34'h0);
        chk(priv_level, PRIV_MACHINE);
        csr_op(1'b0, CSR_MISC, 32'h0);
        chk(rd, 32'h0);
        csr_op(1'b1, CSR_STATUS, 32'h0);
        trap(1'b0, 6'h0, 1'b1, {2'b10, 32'h0});
        trap(1'b0, 6'h0, 1'b1, 34'h0);
        chk(priv_level, PRIV_USER);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
